/* wdcu_assertions.sv */
// Checker for the watchdog control unit, watching the top ports only.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module wdcu_assertions
    import wdcu_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic chip_reset_o,
    input wire logic wdt_irq_o,
    input wire logic wdt_irq_high_prio_o
);
    logic unl_r;
    logic unl_nxt;
    logic ctl_wr;
    logic acc;
    ////////////////////////////////////////////////////////////////
    // Shadow of the unlock bit
    assign ctl_wr = ce_i && wr_i && (addr_i == WDCU_CTRL_OFS);
    assign acc = ctl_wr && unl_r;
    always_comb
    begin
        unl_nxt = unl_r;
        if (ctl_wr)
        begin
            unl_nxt = unl_r ? 1'b0 : wdata_i[WDCU_UNLOCK_BIT];
        end
    end
    always_ff @(posedge sys_clk_i)
    begin
        unl_r <= srst_i ? 1'b0 : unl_nxt;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    AST_PRIO_ROUTE: assert property (wdt_irq_high_prio_o == wdt_irq_o)
        else $error("high priority line differs from timeout irq");
    AST_RDATA_IDLE: assert property ($past(ce_i) && !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    AST_RST_PULSE: assert property (chip_reset_o |=> !chip_reset_o)
        else $error("chip reset longer than one cycle");
    AST_ONE_RESPONSE: assert property ($rose(chip_reset_o) |-> !$rose(wdt_irq_o))
        else $error("reset and irq raised together");
    AST_IRQ_HOLD: assert property ($fell(wdt_irq_o) |-> $past(acc) || $past(srst_i))
        else $error("timeout irq dropped without rewrite");
    AST_RESET_CLEARS: assert property (disable iff (1'b0)
        srst_i && ce_i |=> !chip_reset_o && !wdt_irq_o && rdata_o == 8'h00)
        else $error("outputs not cleared by reset");
    AST_IMMEDIATE: assert property (acc && wdata_i[7:4] == WDCU_PRE_IMMEDIATE
        && wdata_i[1] && !wdata_i[3] |-> ##[1:2] chip_reset_o)
        else $error("immediate reset code gave no reset");
    AST_RESERVED: assert property (acc && wdata_i[7:4] > WDCU_PRE_IMMEDIATE
        && wdata_i[1] |-> ##2 (!chip_reset_o && !wdt_irq_o)[*8])
        else $error("reserved code caused a timeout");
endmodule
bind wdcu_top wdcu_assertions u_wdcu_assertions (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .chip_reset_o(chip_reset_o), .wdt_irq_o(wdt_irq_o),
    .wdt_irq_high_prio_o(wdt_irq_high_prio_o));

/* wdcu_counter.sv */
// Watchdog period counter on the synchronised timebase tick.
// Assumes tick_i is a one-cycle pulse on sys_clk_i.
`timescale 1ns/1ps
module wdcu_counter
    import wdcu_pkg::*;
#(
    parameter int BASE_TICKS = WDCU_BASE_TICKS
)
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    wdcu_timer_if.cnt tmr
);
    logic [WDCU_CNT_W-1:0] cnt_r;
    logic [WDCU_CNT_W-1:0] cnt_nxt;
    logic expire_r;
    logic expire_nxt;
    logic [WDCU_CNT_W-1:0] limit;

    // Power-of-two multiple of the base period
    always_comb
    begin
        limit = WDCU_CNT_W'(BASE_TICKS) << tmr.pre[2:0];
        cnt_nxt = cnt_r;
        expire_nxt = 1'b0;
        if (tmr.clear || !tmr.run)
        begin
            cnt_nxt = '0;
        end
        else if (tick_i)
        begin
            if (cnt_r == limit - WDCU_CNT_W'(1))
            begin
                cnt_nxt = '0;
                expire_nxt = 1'b1;
            end
            else
            begin
                cnt_nxt = cnt_r + WDCU_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            cnt_r <= '0;
            expire_r <= 1'b0;
        end
        else if (ce_i)
        begin
            cnt_r <= cnt_nxt;
            expire_r <= expire_nxt;
        end
    end

    assign tmr.expire = expire_r;
endmodule

/* wdcu_pkg.sv */
// Package for the watchdog control unit: offsets, fields, reset values, timing.
// Assumes a 20 MHz system clock and a 32.768 kHz timebase tick input.
package wdcu_pkg;
    // Register offsets (byte addresses)
    localparam logic [3:0] WDCU_CTRL_OFS = 4'h0;
    localparam logic [3:0] WDCU_IRQ_STAT_OFS = 4'h4;
    localparam logic [3:0] WDCU_IRQ_MASK_OFS = 4'h8;
    // Control register fields
    localparam int WDCU_UNLOCK_BIT = 0;
    localparam int WDCU_ARM_BIT = 1;
    localparam int WDCU_FLAG_BIT = 2;
    localparam int WDCU_RESP_BIT = 3;
    localparam int WDCU_PRE_LSB = 4;
    localparam int WDCU_PRE_W = 4;
    localparam logic [7:0] WDCU_CTRL_RST = 8'h10;
    localparam logic [3:0] WDCU_PRE_MAX_TIMED = 4'h7;
    localparam logic [3:0] WDCU_PRE_IMMEDIATE = 4'h8;
    // Interrupt status bits
    localparam int WDCU_EV_TIMEOUT = 0;
    localparam int WDCU_EV_BAD_WRITE = 1;
    localparam int WDCU_EV_W = 2;
    // Base period 2^9 timebase ticks (15.6 ms at 32.768 kHz)
    localparam int WDCU_BASE_TICKS = 512;
    localparam real WDCU_BASE_MS = 15.6;
    localparam int WDCU_CNT_W = 17;
    typedef enum logic [1:0]
    {
        WDCU_IDLE = 2'b00,
        WDCU_RUN = 2'b01,
        WDCU_EXPIRED = 2'b11
    } wdcu_state_t;
endpackage

/* wdcu_tb_top.sv */
// Self-checking bench for the watchdog control unit.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ps
module wdcu_tb_top
    import wdcu_pkg::*;
;
    localparam int BT = 2;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic tick_pin = 1'b0;
    logic supply_mon = 1'b0;
    logic ce = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_q = 1'b0;
    logic [7:0] rdata_o;
    logic chip_reset_o;
    logic wdt_irq_o;
    logic hp_o;
    logic irq_o;
    logic [7:0] exp_q[$];
    logic [7:0] d;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    int lo;
    wdcu_top #(.BASE_TICKS(BT)) u_wdcu_top (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce),
        .timebase_i(tick_pin), .supply_monitor_i(supply_mon), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chip_reset_o(chip_reset_o),
        .wdt_irq_o(wdt_irq_o), .wdt_irq_high_prio_o(hp_o), .irq_o(irq_o));
    initial forever #25 sys_clk_i = ~sys_clk_i;
    // One timebase tick every 8 clocks
    always
    begin
        repeat (4) @(posedge sys_clk_i);
        tick_pin <= ~tick_pin;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
    endtask
    task automatic arm(input logic [7:0] v);
        wr(WDCU_CTRL_OFS, 8'h01);
        wr(WDCU_CTRL_OFS, v);
    endtask
    // Cycles until a timeout response shows, capped at lim
    task automatic wait_ev(input int lim, output int k);
        k = 0;
        do
        begin
            @(negedge sys_clk_i);
            k++;
        end
        while (wdt_irq_o !== 1'b1 && chip_reset_o !== 1'b1 && k < lim);
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_i)
    begin
        rd_q <= rd_i;
        if (rd_q)
            check("rdata", rdata_o, exp_q.pop_front());
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial
    begin
        void'($urandom(32'h12a62d12));
        repeat (10) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd(WDCU_CTRL_OFS, WDCU_CTRL_RST);
        rd(4'hc, 8'h00);
        d = 8'($urandom) & 8'hfe;
        wr(WDCU_CTRL_OFS, d);
        rd(WDCU_CTRL_OFS, WDCU_CTRL_RST);
        rd(WDCU_IRQ_STAT_OFS, 8'h02);
        wr(WDCU_IRQ_STAT_OFS, 8'h02);
        rd(WDCU_IRQ_STAT_OFS, 8'h00);
        for (int p = 0; p < 8; p++)
        begin
            arm({p[3:0], 4'ha});
            wait_ev(3000, n);
            lo = (BT << p) * 8 - 8;
            check("period", 8'(n >= lo && n <= lo + 24), 8'h01);
            check("irq", 8'(wdt_irq_o), 8'h01);
            check("irq_hp", 8'(hp_o), 8'h01);
        end
        rd(WDCU_CTRL_OFS, 8'h7e);
        wr(WDCU_IRQ_MASK_OFS, 8'h01);
        @(negedge sys_clk_i);
        check("irq_o", 8'(irq_o), 8'h01);
        wr(WDCU_IRQ_STAT_OFS, 8'h01);
        @(negedge sys_clk_i);
        check("irq_o", 8'(irq_o), 8'h00);
        arm(8'h1a);
        repeat (20) @(posedge sys_clk_i);
        arm(8'h1a);
        wait_ev(3000, n);
        check("restart", 8'(n >= 24), 8'h01);
        arm(8'h1a);
        supply_mon <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        supply_mon <= 1'b0;
        rd(WDCU_CTRL_OFS, 8'h18);
        arm(8'h12);
        wait_ev(3000, n);
        check("chip_reset", 8'(chip_reset_o), 8'h01);
        check("irq", 8'(wdt_irq_o), 8'h00);
        rd(WDCU_CTRL_OFS, 8'h14);
        arm(8'h10);
        rd(WDCU_CTRL_OFS, 8'h10);
        arm(8'h92);
        wait_ev(300, n);
        check("reserved", 8'(n == 300), 8'h01);
        arm(8'h82);
        wait_ev(4, n);
        check("immediate", 8'(chip_reset_o), 8'h01);
        // Clock enable low must hold the period count
        arm(8'h0a);
        ce <= 1'b0;
        repeat (100) @(posedge sys_clk_i);
        check("frozen", 8'(wdt_irq_o), 8'h00);
        ce <= 1'b1;
        wait_ev(100, n);
        check("resumed", 8'(wdt_irq_o), 8'h01);
        @(posedge sys_clk_i);
        srst_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd(WDCU_CTRL_OFS, WDCU_CTRL_RST);
        repeat (4) @(posedge sys_clk_i);
        report_and_stop();
    end
endmodule

/* wdcu_timer_if.sv */
// Interface between the control unit and its period counter.
// Assumes both ends run on sys_clk_i.
`timescale 1ns/1ps
interface wdcu_timer_if;
    logic clear;
    logic run;
    logic [3:0] pre;
    logic expire;
    modport ctrl (output clear, output run, output pre, input expire);
    modport cnt (input clear, input run, input pre, output expire);
endinterface

/* wdcu_top.sv */
// Watchdog control unit: control register, unlock, timeout response, irq.
// Assumes a simple strobe register port and an external timebase pin.
// Summary of operation
// - four-bit prescale, base period 15.6 ms
// - timeout interrupt is fixed high priority
// - usable as plain interval timer with interrupt
// - timeout sets flag bit 2
// - flag cleared by writing zero or hardware reset
// - flag survives the watchdog's own reset
// - writing arm one starts and clears counter
// - expiry resets or interrupts per select bit
// - arm cleared by write, wdt reset, reset, supply
// - control write accepted only right after unlock
`timescale 1ns/1ps
module wdcu_top
    import wdcu_pkg::*;
#(
    parameter int BASE_TICKS = WDCU_BASE_TICKS
)
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic timebase_i,
    input wire logic supply_monitor_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic chip_reset_o,
    output logic wdt_irq_o,
    output logic wdt_irq_high_prio_o,
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Timebase pin synchroniser and edge detect
    logic [2:0] tb_sync_r;
    logic tb_seen_r;
    logic tick;

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            tb_sync_r <= 3'h0;
            tb_seen_r <= 1'b0;
        end
        else if (ce_i)
        begin
            tb_sync_r <= {tb_sync_r[1:0], timebase_i};
            if (tb_sync_r[1] == tb_sync_r[2])
            begin
                tb_seen_r <= tb_sync_r[2];
            end
        end
    end

    assign tick = (tb_sync_r[1] == tb_sync_r[2]) && tb_sync_r[2] && !tb_seen_r;

    ////////////////////////////////////////////////////////////////////////////
    // Supply monitor pin synchroniser
    logic [2:0] sm_sync_r;
    logic sm_lvl_r;
    logic sm_event;

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            sm_sync_r <= 3'h0;
            sm_lvl_r <= 1'b0;
        end
        else if (ce_i)
        begin
            sm_sync_r <= {sm_sync_r[1:0], supply_monitor_i};
            if (sm_sync_r[1] == sm_sync_r[2])
            begin
                sm_lvl_r <= sm_sync_r[2];
            end
        end
    end

    assign sm_event = (sm_sync_r[1] == sm_sync_r[2]) && sm_sync_r[2] && !sm_lvl_r;

    ////////////////////////////////////////////////////////////////////////////
    // Control register and state
    wdcu_timer_if tmr ();

    logic [3:0] pre_r;
    logic [3:0] pre_nxt;
    logic resp_r;
    logic resp_nxt;
    logic flag_r;
    logic flag_nxt;
    logic arm_r;
    logic arm_nxt;
    logic unlock_r;
    logic unlock_nxt;
    logic wdt_rst_r;
    logic wdt_rst_nxt;
    logic wdt_irq_r;
    logic wdt_irq_nxt;
    logic [WDCU_EV_W-1:0] stat_r;
    logic [WDCU_EV_W-1:0] stat_nxt;
    logic [WDCU_EV_W-1:0] mask_r;
    logic [WDCU_EV_W-1:0] mask_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    wdcu_state_t state_r;
    wdcu_state_t state_nxt;
    logic ctrl_wr;
    logic ctrl_ok;
    logic timeout;
    logic [WDCU_EV_W-1:0] ev;

    function automatic logic [7:0] ctrl_word(input logic [3:0] p, input logic r,
        input logic f, input logic a, input logic u);
        ctrl_word = {p, r, f, a, u};
    endfunction

    assign ctrl_wr = wr_i && (addr_i == WDCU_CTRL_OFS);
    assign ctrl_ok = ctrl_wr && unlock_r;
    assign timeout = tmr.expire && arm_r;

    always_comb
    begin
        pre_nxt = pre_r;
        resp_nxt = resp_r;
        flag_nxt = flag_r;
        arm_nxt = arm_r;
        unlock_nxt = unlock_r;
        state_nxt = state_r;
        wdt_rst_nxt = 1'b0;
        wdt_irq_nxt = wdt_irq_r;
        tmr.clear = 1'b0;
        ev = '0;
        // Unlock lasts one write; any other control write spends it
        if (ctrl_wr)
        begin
            unlock_nxt = 1'b0;
        end
        if (ctrl_ok)
        begin
            pre_nxt = wdata_i[WDCU_PRE_LSB +: WDCU_PRE_W];
            resp_nxt = wdata_i[WDCU_RESP_BIT];
            arm_nxt = wdata_i[WDCU_ARM_BIT];
            tmr.clear = wdata_i[WDCU_ARM_BIT];
            if (!wdata_i[WDCU_FLAG_BIT])
            begin
                flag_nxt = 1'b0;
            end
            if (wdata_i[WDCU_ARM_BIT])
            begin
                wdt_irq_nxt = 1'b0;
            end
        end
        else if (ctrl_wr)
        begin
            unlock_nxt = wdata_i[WDCU_UNLOCK_BIT];
            ev[WDCU_EV_BAD_WRITE] = !wdata_i[WDCU_UNLOCK_BIT];
        end
        case (state_r)
            WDCU_IDLE:
            begin
                if (arm_nxt)
                begin
                    state_nxt = WDCU_RUN;
                end
            end
            WDCU_RUN:
            begin
                if (!arm_nxt)
                begin
                    state_nxt = WDCU_IDLE;
                end
                else if (pre_r == WDCU_PRE_IMMEDIATE)
                begin
                    wdt_rst_nxt = 1'b1;
                    flag_nxt = 1'b1;
                    arm_nxt = 1'b0;
                    state_nxt = WDCU_IDLE;
                end
                else if (timeout && pre_r <= WDCU_PRE_MAX_TIMED)
                begin
                    flag_nxt = 1'b1;
                    ev[WDCU_EV_TIMEOUT] = 1'b1;
                    if (!resp_r)
                    begin
                        wdt_rst_nxt = 1'b1;
                        arm_nxt = 1'b0;
                        state_nxt = WDCU_IDLE;
                    end
                    else
                    begin
                        wdt_irq_nxt = 1'b1;
                        state_nxt = WDCU_EXPIRED;
                    end
                end
            end
            WDCU_EXPIRED:
            begin
                if (!arm_nxt)
                begin
                    state_nxt = WDCU_IDLE;
                end
                else if (tmr.clear)
                begin
                    state_nxt = WDCU_RUN;
                end
            end
            default:
            begin
                state_nxt = WDCU_IDLE;
            end
        endcase
        if (sm_event)
        begin
            arm_nxt = 1'b0;
            state_nxt = WDCU_IDLE;
        end
    end

    assign tmr.run = (state_r == WDCU_RUN);
    assign tmr.pre = pre_r;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and read data
    always_comb
    begin
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        if (wr_i && addr_i == WDCU_IRQ_STAT_OFS)
        begin
            stat_nxt = stat_r & ~wdata_i[WDCU_EV_W-1:0];
        end
        stat_nxt = stat_nxt | ev;
        if (wr_i && addr_i == WDCU_IRQ_MASK_OFS)
        begin
            mask_nxt = wdata_i[WDCU_EV_W-1:0];
        end
        rdata_nxt = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                WDCU_CTRL_OFS: rdata_nxt = ctrl_word(pre_r, resp_r, flag_r, arm_r, unlock_r);
                WDCU_IRQ_STAT_OFS: rdata_nxt = {6'h00, stat_r};
                WDCU_IRQ_MASK_OFS: rdata_nxt = {6'h00, mask_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            pre_r <= WDCU_CTRL_RST[7:4];
            resp_r <= WDCU_CTRL_RST[WDCU_RESP_BIT];
            flag_r <= WDCU_CTRL_RST[WDCU_FLAG_BIT];
            arm_r <= WDCU_CTRL_RST[WDCU_ARM_BIT];
            unlock_r <= 1'b0;
            state_r <= WDCU_IDLE;
            wdt_rst_r <= 1'b0;
            wdt_irq_r <= 1'b0;
            stat_r <= '0;
            mask_r <= '0;
            rdata_r <= 8'h00;
        end
        else if (ce_i)
        begin
            // Watchdog reset pulse leaves the flag alone
            pre_r <= pre_nxt;
            resp_r <= resp_nxt;
            flag_r <= flag_nxt;
            arm_r <= arm_nxt;
            unlock_r <= unlock_nxt;
            state_r <= state_nxt;
            wdt_rst_r <= wdt_rst_nxt;
            wdt_irq_r <= wdt_irq_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    wdcu_counter #(
        .BASE_TICKS(BASE_TICKS)
    ) u_wdcu_counter (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .tick_i(tick),
        .tmr(tmr)
    );

    assign rdata_o = rdata_r;
    assign chip_reset_o = wdt_rst_r;
    assign wdt_irq_o = wdt_irq_r;
    assign wdt_irq_high_prio_o = wdt_irq_r;
    assign irq_o = |(stat_r & mask_r);
endmodule
